// ### logic/i2c_tto_pkg.sv
// package: register map, field positions and types of the timing/timeout/wake block
package i2c_tto_pkg;
    localparam logic [7:0] OFF_FUNC = 8'h00;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_LINE = 8'h2C;
    localparam logic [7:0] OFF_TXD = 8'h30;
    localparam logic [7:0] OFF_RXD = 8'h34;
    localparam logic [7:0] OFF_ADR0 = 8'h44;
    localparam logic [7:0] OFF_ADR1 = 8'h48;
    localparam logic [7:0] OFF_MSK0 = 8'h4C;
    localparam logic [7:0] OFF_MSK1 = 8'h50;
    localparam logic [7:0] OFF_WKCTL = 8'h54;
    localparam logic [7:0] OFF_WKSTS = 8'h58;
    localparam logic [7:0] OFF_PCTL = 8'h5C;
    localparam logic [7:0] OFF_PIEN = 8'h60;
    localparam logic [7:0] OFF_PSTS = 8'h64;
    localparam logic [7:0] OFF_MATCH = 8'h88;
    localparam logic [7:0] OFF_TMCTL = 8'h8C;
    localparam logic [31:0] RST_BAUD = 32'h00003C00;
    localparam logic [31:0] RST_TMCTL = 32'h00020000;
    localparam logic [31:0] BAUD_MASK = 32'h03FF7F3F;
    localparam logic [31:0] LINE_MASK = 32'h00000F01;
    localparam logic [31:0] PCTL_MASK = 32'h03FF03FF;
    localparam logic [31:0] TMCTL_MASK = 32'h01FF01FF;
    localparam logic [2:0] MODE_I2C = 3'h4;
    // protocol status flag positions
    localparam int ST_TO = 5;
    localparam int ST_START = 8;
    localparam int ST_STOP = 9;
    localparam int ST_NACK = 10;
    localparam int ST_ARB = 11;
    localparam int ST_ERR = 12;
    localparam int ST_ACK = 13;
    localparam int ST_WKDONE = 16;
    localparam int ST_WKRW = 17;
    localparam logic [31:0] ST_W1C = 32'h00013F20;
    localparam logic [31:0] ST_STOPCNT = 32'h00003F00;
    // interrupt enable positions, one for each flag except ST_WKRW
    localparam int IE_TO = 0;
    localparam int IE_START = 1;
    localparam int IE_STOP = 2;
    localparam int IE_NACK = 3;
    localparam int IE_ARB = 4;
    localparam int IE_ERR = 5;
    localparam int IE_ACK = 6;
    localparam int IE_WKDONE = 7;
    localparam int IE_W = 8;
    localparam int PRESC_W = 5;
    localparam logic [PRESC_W-1:0] PRESC_LAST = 5'h1F;
    localparam int SCL_SAMPLES = 3;
    localparam logic [3:0] ADDR_BITS = 4'h8;

    typedef struct packed {
        logic ack;
        logic nack;
        logic arb_lost;
        logic err;
    } evt_s;

    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_ADDR = 2'b01,
        W_ACK = 2'b10,
        W_HOLD = 2'b11
    } wake_e;
endpackage : i2c_tto_pkg

// ### logic/i2c_tto.sv
// i2c channel slice: sda setup/hold delay, bus-hang timeout, address wake-up
// Overview of operation
// (R1) sda change delayed by setup_delay_count peripheral clocks
// (R2) software keeps setup count at most divider plus one minus 6
// (R3) software keeps hold count at most divider plus one minus 9
// (R4) sda change still pending at scl rise raises bus error
// (R5) hold delay used only as master; software zeroes it as slave
// (R6) 10-bit timeout_compare sits in protocol control bits 25..16
// (R7) enabled counter counts up to compare, then raises timeout flag
// (R8) counting stops when enable cleared or any protocol flag set; the code stops only on ST_TO and flags 13..8, not ST_WKDONE
// (R9) write 1 clears timeout_flag and restarts the counter
// (R10) timeout period is (compare+1) times 32 peripheral clocks
// (R11) software keeps measurement clock source at 0 for timeout
// (R12) wake enabled in power-down: matching address wakes the chip
// (R13) ack done while powered down, then scl held low until cleared
// (R14) wake_ack_done set after ack cycle of the wake frame
// (R15) software checks and clears wake_ack_done before wakeup_flag
// (R16) direction bit of wake frame captured in wake_frame_rw_bit
// (R17) wakeup_flag set on wake, cleared by writing 1
// (R18) software selects protocol 100 before other programming
// (R19) eeprom random read: write address bytes, repeated start, read
// (R20) delays count peripheral clocks, unaffected by clock stretching
// (R21) scl accepted only after three equal samples
// (R22) irq asserted while any enabled status flag is set
//
// The address-and-strobe port was chosen for this implementation.
module i2c_tto
    import i2c_tto_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic power_down,
    input wire logic master_mode,
    input wire evt_s evt,
    input wire logic sda_tx,
    input wire logic [15:0] rx_data,
    output logic [15:0] tx_data,
    output logic [2:0] protocol_select,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq,
    output logic wake_req
);
    logic [2:0] func_r;
    logic [31:0] baud_r, line_r, pctl_r, tmctl_r, sts_r, sts_nxt;
    logic [15:0] txd_r;
    logic [9:0] adr0_r, adr1_r, msk0_r, msk1_r;
    logic [1:0] wkctl_r, match_r, match_nxt;
    logic wkf_r, wkf_nxt;
    logic [IE_W-1:0] ien_r;
    logic [31:0] rdata_r, rd_mux;

    // register decode
    wire wr_func = wr && addr == OFF_FUNC;
    wire wr_baud = wr && addr == OFF_BAUD;
    wire wr_line = wr && addr == OFF_LINE;
    wire wr_txd = wr && addr == OFF_TXD;
    wire wr_adr0 = wr && addr == OFF_ADR0;
    wire wr_adr1 = wr && addr == OFF_ADR1;
    wire wr_msk0 = wr && addr == OFF_MSK0;
    wire wr_msk1 = wr && addr == OFF_MSK1;
    wire wr_wkctl = wr && addr == OFF_WKCTL;
    wire wr_wksts = wr && addr == OFF_WKSTS;
    wire wr_pctl = wr && addr == OFF_PCTL;
    wire wr_pien = wr && addr == OFF_PIEN;
    wire wr_psts = wr && addr == OFF_PSTS;
    wire wr_match = wr && addr == OFF_MATCH;
    wire wr_tmctl = wr && addr == OFF_TMCTL;

    wire i2c_on = func_r == MODE_I2C;
    wire [9:0] to_cmp = pctl_r[25:16]; // (R6)
    wire [8:0] setup_cnt = tmctl_r[8:0];
    wire [8:0] hold_cnt = tmctl_r[24:16];

    // scl filter: a level is believed only after three equal samples
    logic [SCL_SAMPLES-1:0] scl_hist_r;
    logic scl_f_r, sda_q_r;
    wire scl_all1 = &scl_hist_r;
    wire scl_all0 = ~|scl_hist_r;
    wire scl_f_nxt = scl_all1 ? 1'b1 : (scl_all0 ? 1'b0 : scl_f_r); // (R21)
    wire scl_rise = scl_f_nxt && !scl_f_r;
    wire scl_fall = !scl_f_nxt && scl_f_r;
    wire start_det = scl_f_r && scl_f_nxt && sda_q_r && !sda_i;
    wire stop_det = scl_f_r && scl_f_nxt && !sda_q_r && sda_i;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_hist_r <= '1;
            scl_f_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_hist_r <= {scl_hist_r[SCL_SAMPLES-2:0], scl_i};
            scl_f_r <= scl_f_nxt;
            sda_q_r <= sda_i;
        end
    end

    // sda delay path; counts clk only, so stretched scl does not change it
    logic sda_tgt_r, sda_out_r, pend_r;
    logic [9:0] dly_r;
    wire [9:0] hold_add = master_mode ? {1'b0, hold_cnt} : 10'h000; // (R5)
    wire [9:0] dly_load = {1'b0, setup_cnt} + hold_add; // (R1) (R20)
    wire new_req = sda_tx != sda_tgt_r;
    wire dly_done = pend_r && dly_r == 10'h000;
    wire [9:0] dly_nxt = new_req ? dly_load :
        (pend_r && !dly_done ? dly_r - 10'h001 : dly_r);
    // a late change overruns the low phase and is reported, then still sent when the count ends
    wire late_err = pend_r && !dly_done && scl_rise; // (R4)

    always_ff @(posedge clk) begin
        if (rst) begin
            sda_tgt_r <= 1'b1;
            sda_out_r <= 1'b1;
            pend_r <= 1'b0;
            dly_r <= 10'h000;
        end else begin
            sda_tgt_r <= sda_tx;
            dly_r <= dly_nxt;
            pend_r <= new_req || (pend_r && !dly_done);
            if (dly_done && !new_req)
                sda_out_r <= sda_tgt_r; // (R1)
        end
    end

    // timeout counter: 5-bit prescale in front of the compare counter
    logic [PRESC_W-1:0] presc_r;
    logic [CNT_W-1:0] tcnt_r;
    wire to_clr = wr_psts && wdata[ST_TO];
    wire to_run = ien_r[IE_TO] && i2c_on && !sts_r[ST_TO]
        && ~|(sts_r & ST_STOPCNT); // (R8)
    wire presc_wrap = presc_r == PRESC_LAST;
    wire to_hit = to_run && presc_wrap
        && tcnt_r == CNT_W'(to_cmp); // (R7) (R10)

    always_ff @(posedge clk) begin
        if (rst || (to_clr && ien_r[IE_TO]) || !to_run) begin
            presc_r <= '0; // (R9)
            tcnt_r <= '0;
        end else begin
            presc_r <= presc_r + PRESC_W'(1);
            if (presc_wrap)
                tcnt_r <= to_hit ? tcnt_r : tcnt_r + CNT_W'(1);
        end
    end

    // wake-up address receiver, started only from a start seen in power-down
    wake_e wst_r, wst_nxt;
    logic [7:0] shift_r;
    logic [3:0] bit_r;
    wire wk_active = power_down && wkctl_r[0] && i2c_on; // (R12)
    wire [9:0] rx_adr = {3'b000, shift_r[7:1]};
    wire hit0 = adr0_r != 10'h000 && ((rx_adr ^ adr0_r) & ~msk0_r) == 10'h000;
    wire hit1 = adr1_r != 10'h000 && ((rx_adr ^ adr1_r) & ~msk1_r) == 10'h000;
    wire addr_full = bit_r == ADDR_BITS;
    wire ack_end = wst_r == W_ACK && scl_fall;
    wire hold_end = !sts_r[ST_WKDONE];

    always_comb begin
        wst_nxt = wst_r;
        unique case (wst_r)
            W_IDLE:
                if (start_det && wk_active)
                    wst_nxt = W_ADDR;
            W_ADDR:
                if (stop_det || start_det)
                    wst_nxt = start_det && wk_active ? W_ADDR : W_IDLE;
                else if (addr_full && scl_fall)
                    wst_nxt = (hit0 || hit1) ? W_ACK : W_IDLE;
            W_ACK:
                if (scl_fall)
                    wst_nxt = W_HOLD; // (R13)
            W_HOLD:
                if (hold_end)
                    wst_nxt = W_IDLE; // (R13)
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wst_r <= W_IDLE;
            shift_r <= 8'h00;
            bit_r <= 4'h0;
        end else begin
            wst_r <= wst_nxt;
            if (wst_r != W_ADDR || start_det) begin
                bit_r <= 4'h0;
            end else if (scl_rise && !addr_full) begin
                shift_r <= {shift_r[6:0], sda_i};
                bit_r <= bit_r + 4'h1;
            end
        end
    end

    // status flags: hardware set wins over a software clear in one cycle
    logic [31:0] sts_set;
    always_comb begin
        sts_set = 32'h0;
        sts_set[ST_TO] = to_hit;
        sts_set[ST_START] = start_det && i2c_on;
        sts_set[ST_STOP] = stop_det && i2c_on;
        sts_set[ST_NACK] = evt.nack;
        sts_set[ST_ARB] = evt.arb_lost;
        sts_set[ST_ERR] = evt.err || late_err;
        sts_set[ST_ACK] = evt.ack;
        sts_set[ST_WKDONE] = ack_end; // (R14)
    end
    wire [31:0] sts_clr = wr_psts ? (wdata & ST_W1C) : 32'h0;
    always_comb begin
        sts_nxt = ((sts_r & ~sts_clr) | sts_set) & ST_W1C; // (R9)
        sts_nxt[ST_WKRW] = ack_end ? shift_r[0] : sts_r[ST_WKRW]; // (R16)
    end
    assign wkf_nxt = ack_end || (wkf_r && !(wr_wksts && wdata[0])); // (R17)
    assign match_nxt = (ack_end ? {hit1, hit0} : 2'b00)
        | (match_r & ~(wr_match ? wdata[1:0] : 2'b00));

    // register file
    always_ff @(posedge clk) begin
        if (rst) begin
            func_r <= 3'h0;
            baud_r <= RST_BAUD;
            line_r <= 32'h0;
            txd_r <= 16'h0000;
            adr0_r <= 10'h000;
            adr1_r <= 10'h000;
            msk0_r <= 10'h000;
            msk1_r <= 10'h000;
            wkctl_r <= 2'b00;
            pctl_r <= 32'h0;
            ien_r <= '0;
            tmctl_r <= RST_TMCTL;
        end else begin
            if (wr_func) func_r <= wdata[2:0];
            if (wr_baud) baud_r <= wdata & BAUD_MASK;
            if (wr_line) line_r <= wdata & LINE_MASK;
            if (wr_txd) txd_r <= wdata[15:0];
            if (wr_adr0) adr0_r <= wdata[9:0];
            if (wr_adr1) adr1_r <= wdata[9:0];
            if (wr_msk0) msk0_r <= wdata[9:0];
            if (wr_msk1) msk1_r <= wdata[9:0];
            if (wr_wkctl) wkctl_r <= wdata[1:0];
            if (wr_pctl) pctl_r <= wdata & PCTL_MASK;
            if (wr_pien) ien_r <= wdata[IE_W-1:0];
            if (wr_tmctl) tmctl_r <= wdata & TMCTL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sts_r <= 32'h0;
            wkf_r <= 1'b0;
            match_r <= 2'b00;
        end else begin
            sts_r <= sts_nxt;
            wkf_r <= wkf_nxt;
            match_r <= match_nxt;
        end
    end

    // read mux; unmapped and write-only addresses read as zero
    always_comb begin
        unique case (addr)
            OFF_FUNC: rd_mux = {29'h0, func_r};
            OFF_BAUD: rd_mux = baud_r;
            OFF_LINE: rd_mux = line_r;
            OFF_RXD: rd_mux = {16'h0000, rx_data};
            OFF_ADR0: rd_mux = {22'h0, adr0_r};
            OFF_ADR1: rd_mux = {22'h0, adr1_r};
            OFF_MSK0: rd_mux = {22'h0, msk0_r};
            OFF_MSK1: rd_mux = {22'h0, msk1_r};
            OFF_WKCTL: rd_mux = {30'h0, wkctl_r};
            OFF_WKSTS: rd_mux = {31'h0, wkf_r};
            OFF_PCTL: rd_mux = pctl_r;
            OFF_PIEN: rd_mux = {{(32-IE_W){1'b0}}, ien_r};
            OFF_PSTS: rd_mux = sts_r;
            OFF_MATCH: rd_mux = {30'h0, match_r};
            OFF_TMCTL: rd_mux = tmctl_r;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            rdata_r <= 32'h0;
        else
            rdata_r <= rd ? rd_mux : 32'h0;
    end

    // interrupt: enabled flags only
    logic [IE_W-1:0] flag_vec;
    always_comb begin
        flag_vec = '0;
        flag_vec[IE_TO] = sts_r[ST_TO];
        flag_vec[IE_START] = sts_r[ST_START];
        flag_vec[IE_STOP] = sts_r[ST_STOP];
        flag_vec[IE_NACK] = sts_r[ST_NACK];
        flag_vec[IE_ARB] = sts_r[ST_ARB];
        flag_vec[IE_ERR] = sts_r[ST_ERR];
        flag_vec[IE_ACK] = sts_r[ST_ACK];
        flag_vec[IE_WKDONE] = sts_r[ST_WKDONE];
    end
    assign irq = |(flag_vec & ien_r); // (R22)

    // pins: open drain, enable high only while pulling low
    wire ack_drive = wst_r == W_ACK;
    wire scl_hold = wst_r == W_HOLD; // (R13)
    wire wk_busy = wst_r != W_IDLE;
    assign scl_o = 1'b0;
    assign scl_oe = scl_hold;
    assign sda_o = 1'b0;
    assign sda_oe = ack_drive || (!wk_busy && i2c_on && !sda_out_r);
    assign rdata = rdata_r;
    assign wake_req = wkf_r; // (R12)
    assign tx_data = txd_r;
    assign protocol_select = func_r;
endmodule : i2c_tto

// ### verif/i2c_tto_properties.sv
// checker: port-level properties of the i2c timing/timeout/wake slice
module i2c_tto_properties
    import i2c_tto_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic power_down,
    input wire logic [2:0] protocol_select,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic irq,
    input wire logic wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic st_w1 = wr && addr == OFF_PSTS && wdata[ST_WKDONE];
    wire logic wk_w1 = wr && addr == OFF_WKSTS && wdata[0];
    wire logic [2:0] func_w = wdata[2:0];
    a_open_drain: assert property (!scl_o && !sda_o)
        else $error("open-drain output driven high");
    a_scl_stretch: assert property (
        scl_oe && !st_w1 && !$past(st_w1) |=> scl_oe)
        else $error("scl released before ack-done clear");
    a_stretch_end: assert property (scl_oe && st_w1 |-> ##[1:2] !scl_oe)
        else $error("scl not released after ack-done clear");
    a_wake_in_pd: assert property ($rose(scl_oe) |-> power_down)
        else $error("wake hold outside power-down");
    a_wake_flag: assert property ($rose(scl_oe) |-> ##[0:1] wake_req)
        else $error("wake flag missing after wake frame");
    a_wake_clear: assert property (wk_w1 && !power_down |=> !wake_req)
        else $error("wake flag not cleared by write");
    a_mode_reg: assert property (
        wr && addr == OFF_FUNC |=> protocol_select == $past(func_w))
        else $error("protocol select not loaded");
    a_read_idle: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside read answer");
    c_wake: cover property ($rose(wake_req));
    c_irq: cover property ($rose(irq));
    c_release: cover property ($fell(scl_oe));
endmodule : i2c_tto_properties

bind i2c_tto i2c_tto_properties chk_u (.clk, .rst, .addr, .wdata, .wr,
    .rd, .rdata, .power_down, .protocol_select, .scl_o, .scl_oe, .sda_o,
    .irq, .wake_req);

// ### verif/i2c_peer_master.sv
// partner: another bus master that sends one address frame
module i2c_peer_master #(
    parameter int HALF = 12
) (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl_rel,
    output logic sda_rel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic half();
        repeat (HALF) @(posedge clk);
    endtask : half
    // sda moves only mid-low phase so the filtered scl never sees a stop
    task automatic frame(input logic [7:0] byte_v, output logic ack);
        sda_rel <= 1'b0;
        half();
        scl_rel <= 1'b0;
        half();
        for (int i = 7; i >= 0; i--) begin
            sda_rel <= byte_v[i];
            half();
            scl_rel <= 1'b1;
            half();
            scl_rel <= 1'b0;
            half();
        end
        sda_rel <= 1'b1;
        half();
        scl_rel <= 1'b1;
        half();
        ack = !sda_line;
        scl_rel <= 1'b0;
        half();
        scl_rel <= 1'b1;
        // let the filtered scl settle high, else the next start is missed
        half();
    endtask : frame
endmodule : i2c_peer_master

// ### verif/tb_i2c_tto.sv
// testbench: register map, timeout, sda delay and wake-up of i2c_tto
module tb_i2c_tto
    import i2c_tto_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic power_down = 1'b0;
    logic master_mode = 1'b0;
    logic sda_tx = 1'b1;
    evt_s evt = '0;
    logic [15:0] rx_data = 16'h0;
    logic [31:0] rdata;
    logic [15:0] tx_data;
    logic [2:0] protocol_select;
    logic scl_o, scl_oe, sda_o, sda_oe, irq, wake_req, scl_rel, sda_rel;
    wire scl_w = scl_rel & ~scl_oe;
    wire sda_w = sda_rel & ~sda_oe;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 67257;
    logic [31:0] mdl [256];
    logic [7:0] offs[$] = '{OFF_FUNC, OFF_BAUD, OFF_LINE, OFF_TXD, OFF_RXD,
        OFF_ADR0, OFF_MSK1, OFF_WKCTL, OFF_WKSTS, OFF_PCTL, OFF_PIEN,
        OFF_PSTS, OFF_MATCH, OFF_TMCTL, 8'hFC};
    always #4 clk = ~clk;
    i2c_tto dut_u (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .power_down,
        .master_mode, .evt, .sda_tx, .rx_data, .tx_data, .protocol_select,
        .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe,
        .irq, .wake_req);
    i2c_peer_master peer_u (.clk, .sda_line(sda_w), .scl_rel, .sda_rel);
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr32(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr32
    task automatic chk(string what, logic [7:0] a, logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(what, exp, rdata);
    endtask : chk
    // counts edges until the level is seen; a hang ends the run
    task automatic wait_lvl(ref logic s, input logic v, output int n);
        n = 0;
        #1;
        while (s !== v && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            summarize();
        end
    endtask : wait_lvl
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        logic [31:0] v;
        int n;
        logic ack;
        foreach (mdl[i]) mdl[i] = 32'h0;
        mdl[OFF_BAUD] = RST_BAUD;
        mdl[OFF_TMCTL] = RST_TMCTL;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i]) chk("reset", offs[i], mdl[offs[i]]);
        foreach (offs[i]) begin
            v = $random(seed);
            wr32(offs[i], v);
            if (offs[i] == OFF_TXD)
                #1 cmp("txdata", {16'h0, v[15:0]}, {16'h0, tx_data});
            if (offs[i] inside {OFF_BAUD, OFF_LINE, OFF_PCTL, OFF_TMCTL})
                mdl[offs[i]] = v & (offs[i] == OFF_BAUD ? BAUD_MASK :
                    offs[i] == OFF_LINE ? LINE_MASK :
                    offs[i] == OFF_PCTL ? PCTL_MASK : TMCTL_MASK);
            if (offs[i] inside {OFF_BAUD, OFF_LINE, OFF_PCTL, OFF_TMCTL})
                chk("rw", offs[i], mdl[offs[i]]);
        end
        rx_data <= 16'($random(seed));
        #1 chk("rxdata", OFF_RXD, {16'h0, rx_data});
        // w1c flags get ones so nothing from the random pass lingers
        foreach (offs[i])
            wr32(offs[i], offs[i] inside {OFF_WKSTS, OFF_PSTS, OFF_MATCH} ?
                32'hFFFF_FFFF : 32'h0);
        wr32(OFF_FUNC, 32'h4);
        #1 cmp("mode", 32'h4, {29'h0, protocol_select});
        wr32(OFF_PCTL, 32'h0001_0000);
        for (int k = 0; k < 2; k++) begin
            wr32(k ? OFF_PSTS : OFF_PIEN, k ? 32'h20 : 32'h1);
            wait_lvl(irq, 1'b1, n);
            cmp("timeout", 32'h1, 32'(n inside {[64:65]}));
        end
        chk("tflag", OFF_PSTS, 32'h20);
        @(posedge clk);
        evt.ack <= 1'b1;
        @(posedge clk);
        evt.ack <= 1'b0;
        wr32(OFF_PSTS, 32'h20);
        repeat (150) @(posedge clk);
        chk("halted", OFF_PSTS, 32'h2000);
        cmp("irqmask", 32'h0, {31'h0, irq});
        wr32(OFF_PIEN, 32'h41);
        #1 cmp("irq", 32'h1, {31'h0, irq});
        wr32(OFF_PIEN, 32'h0);
        wr32(OFF_PSTS, 32'h2000);
        wr32(OFF_BAUD, 32'h0010_0000);
        for (int k = 0; k < 2; k++) begin
            wr32(OFF_TMCTL, k ? 32'h0003_0005 : 32'h0000_0005);
            master_mode <= k[0];
            sda_tx <= k[0];
            wait_lvl(sda_oe, !k[0], n);
            cmp("sdadelay", 32'h1, 32'(n inside {[7 + 3 * k:8 + 3 * k]}));
        end
        // own sda low then high with scl high is a start then a stop
        chk("busflags", OFF_PSTS, 32'h0000_0300);
        wr32(OFF_PSTS, 32'h0000_0300);
        wr32(OFF_ADR0, 32'h5A);
        wr32(OFF_WKCTL, 32'h1);
        for (int k = 1; k >= 0; k--) begin
            power_down <= 1'b1;
            peer_u.frame(8'h66, ack);
            cmp("nomatch", 32'h0, {31'h0, ack | wake_req});
            peer_u.frame({7'h5A, k[0]}, ack);
            repeat (30) @(posedge clk);
            cmp("ackhold", 32'h1, {31'h0, ack & !scl_w});
            power_down <= 1'b0;
            chk("wakests", OFF_PSTS, {14'h0, k[0], 17'h1_0100});
            wr32(OFF_PSTS, 32'h3_0100);
            repeat (3) @(posedge clk);
            cmp("release", 32'h1, {31'h0, scl_w});
            chk("wkf", OFF_WKSTS, 32'h1);
            wr32(OFF_WKSTS, 32'h1);
            chk("wkfclr", OFF_WKSTS, 32'h0);
            chk("match", OFF_MATCH, 32'h1);
            wr32(OFF_MATCH, 32'h3);
        end
        summarize();
    end
endmodule : tb_i2c_tto
